// ---- hdl/pcpc_defs.vh ----
// Purpose: shared constants of the clock and power control block
// Assumes: 32-bit byte addresses on the processor memory-mapped bus
// Notes:   definitions only
`ifndef PCPC_DEFS_VH
`define PCPC_DEFS_VH

// ****************************************
// register addresses
// ****************************************
`define PCPC_ADDR_POW_KEY1  32'hffff0404
`define PCPC_ADDR_POW_CTRL  32'hffff0408
`define PCPC_ADDR_POW_KEY2  32'hffff040c
`define PCPC_ADDR_PLL_KEY1  32'hffff0410
`define PCPC_ADDR_PLL_SRC   32'hffff0414
`define PCPC_ADDR_PLL_KEY2  32'hffff0418

// ****************************************
// key values
// ****************************************
`define PCPC_POW_KEY1_VAL   16'h0001
`define PCPC_POW_KEY2_VAL   16'h00f4
`define PCPC_PLL_KEY1_VAL   16'h00aa
`define PCPC_PLL_KEY2_VAL   16'h0055

// ****************************************
// reset values and field positions
// ****************************************
`define PCPC_POW_RESET      8'h7b
`define PCPC_PLL_RESET      3'h0
`define PCPC_POW_RSVD       7
`define PCPC_POW_XTAL       6
`define PCPC_POW_PLL        5
`define PCPC_POW_PERI       4
`define PCPC_POW_CORE       3
`define PCPC_POW_CD_MSB     2
`define PCPC_PLL_EXT        2
`define PCPC_PLL_OSCILLATOR_SELECT_MSB   1
`define PCPC_OSCILLATOR_SELECT_CRYSTAL   2'h2

// ****************************************
// active pll source encodings
// ****************************************
`define PCPC_SRC_INT        2'h0
`define PCPC_SRC_XTAL       2'h1
`define PCPC_SRC_EXT        2'h2

`endif

// ---- hdl/pcpc_key_gate.v ----
// Purpose: key bracket checker for one protected register
// Assumes: each bus read or write is one instruction
// Notes:   o_take marks the protected write, o_commit the closing key
`timescale 1ns/1ps
module pcpc_key_gate #(
    parameter [31:0] KEY1_ADDR = 32'h00000000,
    parameter [15:0] KEY1_VAL  = 16'h0000,
    parameter [31:0] REG_ADDR  = 32'h00000000,
    parameter [31:0] KEY2_ADDR = 32'h00000000,
    parameter [15:0] KEY2_VAL  = 16'h0000
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_bus_wr,
    input  wire        i_bus_rd,
    input  wire [31:0] i_bus_addr,
    input  wire [15:0] i_bus_wdata,
    output reg         o_take,
    output reg         o_commit
);

    localparam [2:0] S_IDLE  = 3'h1;
    localparam [2:0] S_ARMED = 3'h2;
    localparam [2:0] S_HELD  = 3'h4;

    reg  [2:0] state;
    reg  [2:0] next_state;
    wire       access = i_bus_wr | i_bus_rd;

    function f_key;
        input        wr;
        input [31:0] addr;
        input [15:0] data;
        input [31:0] kaddr;
        input [15:0] kval;
        begin
            f_key = wr && (addr == kaddr) && (data == kval);
        end
    endfunction

    wire key1_hit = f_key(i_bus_wr, i_bus_addr, i_bus_wdata, KEY1_ADDR, KEY1_VAL);
    wire key2_hit = f_key(i_bus_wr, i_bus_addr, i_bus_wdata, KEY2_ADDR, KEY2_VAL);
    wire reg_hit  = i_bus_wr && (i_bus_addr == REG_ADDR);

    // ****************************************
    // sequence tracking
    // ****************************************
    always @* begin
        next_state = state;
        o_take     = 1'b0;
        o_commit   = 1'b0;
        if (access) begin
            case (state)
                S_IDLE: begin
                    next_state = key1_hit ? S_ARMED : S_IDLE;
                end
                S_ARMED: begin
                    if (reg_hit) begin
                        next_state = S_HELD;
                        o_take     = 1'b1;
                    end else begin
                        next_state = key1_hit ? S_ARMED : S_IDLE;
                    end
                end
                S_HELD: begin
                    o_commit   = key2_hit;
                    next_state = key1_hit ? S_ARMED : S_IDLE;
                end
                default: begin
                    next_state = S_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

endmodule

// ---- hdl/pcpc_core_div.v ----
// Purpose: glitch-free binary divider making the core clock
// Assumes: i_tick pulses at twice the system pll clock rate
// Notes:   a new divider is taken only at the end of a full period
`timescale 1ns/1ps
module pcpc_core_div #(
    parameter DIV_W = 3,
    parameter CNT_W = 7
) (
    input  wire             i_ref_clk,
    input  wire             i_rst_n,
    input  wire             i_tick,
    input  wire             i_run,
    input  wire [DIV_W-1:0] i_div,
    input  wire [DIV_W-1:0] i_div_reset,
    output reg              o_core_clk,
    output reg              o_core_tick,
    output reg  [DIV_W-1:0] o_div_active
);

    reg  [CNT_W-1:0] cnt;
    reg              primed;
    wire [CNT_W-1:0] term = ~({CNT_W{1'b1}} << o_div_active);
    wire             wrap = i_tick && (cnt == term);

    // ****************************************
    // divider
    // ****************************************
    // reset value of the divider comes in as a constant port, tied at the top;
    // it is loaded on the first edge after reset so the reset branch stays constant
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            primed       <= 1'b0;
            cnt          <= {CNT_W{1'b0}};
            o_core_clk   <= 1'b0;
            o_core_tick  <= 1'b0;
            o_div_active <= {DIV_W{1'b0}};
        end else begin
            o_core_tick <= 1'b0;
            if (!primed) begin
                // reset divider before the first phase runs
                primed       <= 1'b1;
                o_div_active <= i_div_reset;
            end else if (!o_core_clk && (cnt == {CNT_W{1'b0}}) && !i_run) begin
                // parked low at a period boundary, no short phase
                o_div_active <= i_div;
            end else if (wrap) begin
                cnt        <= {CNT_W{1'b0}};
                o_core_clk <= ~o_core_clk;
                if (!o_core_clk) begin
                    o_core_tick <= 1'b1;
                end else begin
                    o_div_active <= i_div;
                end
            end else if (i_tick) begin
                cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ---- hdl/pcpc_top.v ----
// Purpose: pll source selection, core clock divider and power-down control
// Assumes: memory-mapped bus with one access per instruction, inputs synchronous
// Notes:   pll and crystal themselves are analog; this block drives their controls
//
// Summary of operation
// - pll locks to internal or crystal 32.768 kHz, gives 10.24 MHz
// - core clock is system clock divided by two to the divider
// - divider resets to 3, core runs at 1.28 MHz
// - divider is bits 2 to 0, codes 000..111 give 10.24 MHz..80 kHz
// - on wake from nap after crystal request the crystal is active
// - external clock pin in mode 0 is divided by two internally
// - internal oscillator feeds pll after reset; source chosen only by register
// - power write needs first power key 0x01 just before
// - power write completes with second power key 0xf4 just after
// - pll source write bracketed by keys 0xaa before and 0x55 after
// - bit 2 selects external pin; select code 10 picks crystal
// - bit 6 powers crystal circuitry up when set, down when clear
// - clearing bit 5 powers the pll and pll-clocked timers down
// - pll powers down only with bits 3, 4 and 5 cleared together
// - clearing bit 4 powers peripherals down only with bit 3 cleared
// - clearing bit 3 powers the core down; software adds a dummy cycle
// - bits 5, 4, 3 set at reset and set again on wake-up
`timescale 1ns/1ps
`include "pcpc_defs.vh"
module pcpc_top #(
    parameter DIV_W = 3,
    parameter CNT_W = 7
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_bus_wr,
    input  wire        i_bus_rd,
    input  wire [31:0] i_bus_addr,
    input  wire [15:0] i_bus_wdata,
    output reg  [15:0] o_bus_rdata,
    output reg         o_bus_rvalid,
    input  wire        i_wake,
    input  wire        i_pll_tick,
    input  wire        i_ext_clk_pin,
    input  wire        i_ext_pin_mode0,
    output wire        o_core_clk,
    output wire        o_core_tick,
    output wire [2:0]  o_core_divider,
    output reg         o_crystal_power_en,
    output reg         o_pll_power_en,
    output reg         o_periph_power_en,
    output reg         o_core_power_en,
    output reg  [1:0]  o_pll_source,
    output reg         o_ext_clk_div2,
    output reg         o_ext_clk_tick
);

    // ****************************************
    // register state
    // ****************************************
    reg  [7:0] power_clock_control;
    reg  [2:0] pll_source_control;
    reg  [7:0] pow_pend;
    reg  [2:0] pll_pend;
    reg        ext_pin_prev;
    reg  [7:0] next_power;
    wire       pow_take;
    wire       pow_commit;
    wire       pll_take;
    wire       pll_commit;
    wire [1:0] want_src;
    wire [7:0] pow_reset_val = `PCPC_POW_RESET;

    // requested pll source from the source control bits
    function [1:0] f_src;
        input [2:0] ctl;
        begin
            if (ctl[`PCPC_PLL_EXT]) begin
                f_src = `PCPC_SRC_EXT;
            end else if (ctl[`PCPC_PLL_OSCILLATOR_SELECT_MSB:0] == `PCPC_OSCILLATOR_SELECT_CRYSTAL) begin
                f_src = `PCPC_SRC_XTAL;
            end else begin
                f_src = `PCPC_SRC_INT;
            end
        end
    endfunction

    assign want_src = f_src(pll_source_control);

    // ****************************************
    // key sequences
    // ****************************************
    pcpc_key_gate #(
        .KEY1_ADDR (`PCPC_ADDR_POW_KEY1),
        .KEY1_VAL  (`PCPC_POW_KEY1_VAL),
        .REG_ADDR  (`PCPC_ADDR_POW_CTRL),
        .KEY2_ADDR (`PCPC_ADDR_POW_KEY2),
        .KEY2_VAL  (`PCPC_POW_KEY2_VAL)
    ) u_pow_gate (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_bus_wr    (i_bus_wr),
        .i_bus_rd    (i_bus_rd),
        .i_bus_addr  (i_bus_addr),
        .i_bus_wdata (i_bus_wdata),
        .o_take      (pow_take),
        .o_commit    (pow_commit)
    );

    pcpc_key_gate #(
        .KEY1_ADDR (`PCPC_ADDR_PLL_KEY1),
        .KEY1_VAL  (`PCPC_PLL_KEY1_VAL),
        .REG_ADDR  (`PCPC_ADDR_PLL_SRC),
        .KEY2_ADDR (`PCPC_ADDR_PLL_KEY2),
        .KEY2_VAL  (`PCPC_PLL_KEY2_VAL)
    ) u_pll_gate (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_bus_wr    (i_bus_wr),
        .i_bus_rd    (i_bus_rd),
        .i_bus_addr  (i_bus_addr),
        .i_bus_wdata (i_bus_wdata),
        .o_take      (pll_take),
        .o_commit    (pll_commit)
    );

    // ****************************************
    // power control update
    // ****************************************
    always @* begin
        next_power = pow_pend;
        next_power[`PCPC_POW_RSVD] = 1'b0;
        // peripherals stay up while core stays up
        next_power[`PCPC_POW_PERI] = pow_pend[`PCPC_POW_PERI] | pow_pend[`PCPC_POW_CORE];
        // pll stays up unless all three cleared
        next_power[`PCPC_POW_PLL] = pow_pend[`PCPC_POW_PLL] | pow_pend[`PCPC_POW_PERI] |
                                    pow_pend[`PCPC_POW_CORE];
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            power_clock_control <= `PCPC_POW_RESET;
            pow_pend            <= `PCPC_POW_RESET;
            pll_source_control  <= `PCPC_PLL_RESET;
            pll_pend            <= `PCPC_PLL_RESET;
        end else begin
            // pending data waits for the closing key
            if (pow_take) begin
                pow_pend <= i_bus_wdata[7:0];
            end
            if (pll_take) begin
                pll_pend <= i_bus_wdata[2:0];
            end
            if (pow_commit) begin
                power_clock_control <= next_power;
            end
            // wake wins over a same-cycle power-down of bits 5, 4 and 3
            if (i_wake) begin
                power_clock_control[`PCPC_POW_PLL]  <= 1'b1;
                power_clock_control[`PCPC_POW_PERI] <= 1'b1;
                power_clock_control[`PCPC_POW_CORE] <= 1'b1;
            end
            // pll source lands on closing key
            if (pll_commit) begin
                pll_source_control <= pll_pend;
            end
        end
    end

    // ****************************************
    // power outputs and pll source
    // ****************************************
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_crystal_power_en <= 1'b1;
            o_pll_power_en     <= 1'b1;
            o_periph_power_en  <= 1'b1;
            o_core_power_en    <= 1'b1;
            o_pll_source       <= `PCPC_SRC_INT;
        end else begin
            o_crystal_power_en <= power_clock_control[`PCPC_POW_XTAL];
            o_pll_power_en     <= power_clock_control[`PCPC_POW_PLL];
            o_periph_power_en  <= power_clock_control[`PCPC_POW_PERI];
            o_core_power_en    <= power_clock_control[`PCPC_POW_CORE];
            // crystal switch-over happens while the core naps
            // so the core never sees the pll relock
            if (want_src != `PCPC_SRC_XTAL) begin
                o_pll_source <= want_src;
            end else if (!power_clock_control[`PCPC_POW_CORE]) begin
                o_pll_source <= `PCPC_SRC_XTAL;
            end
        end
    end

    // ****************************************
    // external clock divide by two
    // ****************************************
    // pin is sampled at the reference rate; inputs above half of it are not caught
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_pin_prev   <= 1'b0;
            o_ext_clk_div2 <= 1'b0;
            o_ext_clk_tick <= 1'b0;
        end else begin
            ext_pin_prev   <= i_ext_clk_pin;
            o_ext_clk_tick <= 1'b0;
            // toggle on each rising pin edge
            if ((o_pll_source == `PCPC_SRC_EXT) && i_ext_pin_mode0 &&
                i_ext_clk_pin && !ext_pin_prev) begin
                o_ext_clk_div2 <= ~o_ext_clk_div2;
                o_ext_clk_tick <= ~o_ext_clk_div2;
            end
        end
    end

    // ****************************************
    // core clock
    // ****************************************
    // core clock is divided pll clock
    pcpc_core_div #(
        .DIV_W (DIV_W),
        .CNT_W (CNT_W)
    ) u_core_div (
        .i_ref_clk    (i_ref_clk),
        .i_rst_n      (i_rst_n),
        .i_tick       (i_pll_tick),
        .i_run        (o_core_power_en),
        .i_div        (power_clock_control[`PCPC_POW_CD_MSB:0]),
        .i_div_reset  (pow_reset_val[`PCPC_POW_CD_MSB:0]),
        .o_core_clk   (o_core_clk),
        .o_core_tick  (o_core_tick),
        .o_div_active (o_core_divider)
    );

    // ****************************************
    // register read back
    // ****************************************
    // key registers are write only and read as zero, like unmapped addresses
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_rdata  <= 16'h0000;
            o_bus_rvalid <= 1'b0;
        end else begin
            o_bus_rvalid <= i_bus_rd;
            if (i_bus_rd) begin
                case (i_bus_addr)
                    `PCPC_ADDR_POW_CTRL: begin
                        o_bus_rdata <= {8'h00, power_clock_control};
                    end
                    `PCPC_ADDR_PLL_SRC: begin
                        o_bus_rdata <= {13'h0000, pll_source_control};
                    end
                    default: begin
                        o_bus_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end

endmodule

// ---- verification/pcpc_top_chk.sv ----
// Purpose: port-level checks of pcpc_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps
`include "pcpc_defs.vh"
module pcpc_top_chk #(
    parameter DIV_W = 3,
    parameter CNT_W = 7
) (
    input wire        i_ref_clk,
    input wire        i_rst_n,
    input wire        i_bus_wr,
    input wire        i_bus_rd,
    input wire [31:0] i_bus_addr,
    input wire [15:0] i_bus_wdata,
    input wire [15:0] o_bus_rdata,
    input wire        o_bus_rvalid,
    input wire        i_wake,
    input wire        i_pll_tick,
    input wire        i_ext_clk_pin,
    input wire        i_ext_pin_mode0,
    input wire        o_core_clk,
    input wire        o_core_tick,
    input wire [2:0]  o_core_divider,
    input wire        o_crystal_power_en,
    input wire        o_pll_power_en,
    input wire        o_periph_power_en,
    input wire        o_core_power_en,
    input wire [1:0]  o_pll_source,
    input wire        o_ext_clk_div2,
    input wire        o_ext_clk_tick
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    wire [2:0] pwr    = {o_pll_power_en, o_periph_power_en, o_core_power_en};
    wire       key2_w = i_bus_wr && (i_bus_addr == `PCPC_ADDR_POW_KEY2);

    // ****************************************
    // assertions
    // ****************************************
    a_read_answer: assert property (o_bus_rvalid == $past(i_bus_rd))
        else $error("read answer out of step");
    a_key_reads_zero: assert property
        ((i_bus_rd && i_bus_addr == `PCPC_ADDR_POW_KEY1) |=> o_bus_rdata == 16'h0000)
        else $error("key read not zero");
    a_reset_powered: assert property
        ($rose(i_rst_n) |-> pwr == 3'h7 && o_crystal_power_en && o_pll_source == 2'h0)
        else $error("power or source wrong after reset");
    a_wake_restores: assert property (i_wake |-> ##2 pwr == 3'h7)
        else $error("wake did not restore power");
    a_pll_off_all: assert property
        (!o_pll_power_en |-> !o_periph_power_en && !o_core_power_en)
        else $error("pll off while core or peripherals on");
    a_peri_off_core: assert property (!o_periph_power_en |-> !o_core_power_en)
        else $error("peripherals off while core on");
    a_power_held: assert property
        (!$stable({o_crystal_power_en, pwr}) |-> $past(key2_w, 2) || $past(i_wake, 2))
        else $error("power enables changed without a commit");
    a_div_at_low: assert property ($changed(o_core_divider) |-> !o_core_clk)
        else $error("divider changed during high phase");
    a_ext_div_follow: assert property
        (($rose(i_ext_clk_pin) && i_ext_pin_mode0 && o_pll_source == 2'h2)
         |-> ##[1:2] $changed(o_ext_clk_div2))
        else $error("external clock half rate missed an edge");
    a_crystal_nap: assert property
        (($changed(o_pll_source) && o_pll_source == 2'h1)
         |-> !o_core_power_en || !$past(o_core_power_en))
        else $error("crystal applied while core awake");
endmodule

bind pcpc_top pcpc_top_chk #(.DIV_W(DIV_W), .CNT_W(CNT_W)) i_pcpc_top_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus_wr(i_bus_wr),
    .i_bus_rd(i_bus_rd), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(o_bus_rdata), .o_bus_rvalid(o_bus_rvalid), .i_wake(i_wake),
    .i_pll_tick(i_pll_tick), .i_ext_clk_pin(i_ext_clk_pin),
    .i_ext_pin_mode0(i_ext_pin_mode0), .o_core_clk(o_core_clk),
    .o_core_tick(o_core_tick), .o_core_divider(o_core_divider),
    .o_crystal_power_en(o_crystal_power_en), .o_pll_power_en(o_pll_power_en),
    .o_periph_power_en(o_periph_power_en), .o_core_power_en(o_core_power_en),
    .o_pll_source(o_pll_source), .o_ext_clk_div2(o_ext_clk_div2),
    .o_ext_clk_tick(o_ext_clk_tick));

// ---- verification/pcpc_top_tb_top.sv ----
// Purpose: self-checking bench of pcpc_top through its register bus
// Assumes: pll tick model pulses every cycle, so core period is 2^(div+1) cycles
// Notes:   all inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`include "pcpc_defs.vh"
module pcpc_top_tb_top;
    reg         ref_clk   = 1'b0;
    reg         rst_n     = 1'b0;
    reg         bus_wr    = 1'b0;
    reg         bus_rd    = 1'b0;
    reg  [31:0] bus_addr  = 32'h00000000;
    reg  [15:0] bus_wdata = 16'h0000;
    reg         wake      = 1'b0;
    reg         ext_pin   = 1'b0;
    reg         ext_mode0 = 1'b0;
    reg  [15:0] ext_cnt   = 16'h0000;
    reg  [15:0] ext_base;
    reg  [15:0] rd_val;
    reg  [15:0] gap;
    wire [15:0] bus_rdata;
    wire [2:0]  core_div;
    wire [1:0]  src;
    wire        bus_rvalid, core_clk, core_tick, xtal_en, pll_en, peri_en, core_en;
    wire        ext_div2, ext_tick;
    integer     num_errors = 0;
    integer     checks     = 0;
    integer     i;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (ext_tick === 1'b1) ext_cnt <= ext_cnt + 16'h0001;

    pcpc_top i_pcpc_top (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
        .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata),
        .o_bus_rvalid(bus_rvalid), .i_wake(wake), .i_pll_tick(1'b1),
        .i_ext_clk_pin(ext_pin), .i_ext_pin_mode0(ext_mode0), .o_core_clk(core_clk),
        .o_core_tick(core_tick), .o_core_divider(core_div),
        .o_crystal_power_en(xtal_en), .o_pll_power_en(pll_en),
        .o_periph_power_en(peri_en), .o_core_power_en(core_en), .o_pll_source(src),
        .o_ext_clk_div2(ext_div2), .o_ext_clk_tick(ext_tick));

    // ****************************************
    // bench tasks
    // ****************************************
    task stop_test;
        begin
            if (num_errors == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task bus_write(input [31:0] a, input [15:0] d);
        begin
            @(posedge ref_clk);
            bus_wr    <= 1'b1;
            bus_addr  <= a;
            bus_wdata <= d;
            @(posedge ref_clk);
            bus_wr <= 1'b0;
        end
    endtask
    // a missing answer ends the run rather than hanging it
    task bus_read(input [31:0] a, output [15:0] v);
        integer n;
        begin
            @(posedge ref_clk);
            bus_rd   <= 1'b1;
            bus_addr <= a;
            @(posedge ref_clk);
            bus_rd <= 1'b0;
            n = 0;
            #1;
            while (bus_rvalid !== 1'b1) begin
                if (n == 4) begin
                    num_errors = num_errors + 1;
                    stop_test;
                end
                @(posedge ref_clk);
                #1;
                n = n + 1;
            end
            v = bus_rdata;
        end
    endtask
    task check_read(input [31:0] a, input [15:0] exp);
        begin
            bus_read(a, rd_val);
            check(rd_val, exp);
        end
    endtask
    task pow_seq(input [15:0] d);
        begin
            bus_write(`PCPC_ADDR_POW_KEY1, `PCPC_POW_KEY1_VAL);
            bus_write(`PCPC_ADDR_POW_CTRL, d);
            bus_write(`PCPC_ADDR_POW_KEY2, `PCPC_POW_KEY2_VAL);
        end
    endtask
    task pll_seq(input [15:0] d, input [15:0] exp_src);
        begin
            bus_write(`PCPC_ADDR_PLL_KEY1, `PCPC_PLL_KEY1_VAL);
            bus_write(`PCPC_ADDR_PLL_SRC, d);
            bus_write(`PCPC_ADDR_PLL_KEY2, `PCPC_PLL_KEY2_VAL);
            repeat (3) @(posedge ref_clk);
            #1;
            check({14'h0000, src}, exp_src);
        end
    endtask
    task bad_pow(input [15:0] k1, input [15:0] k2);
        begin
            bus_write(`PCPC_ADDR_POW_KEY1, k1);
            bus_write(`PCPC_ADDR_POW_CTRL, 16'h0078);
            bus_write(`PCPC_ADDR_POW_KEY2, k2);
            check_read(`PCPC_ADDR_POW_CTRL, 16'h007b);
        end
    endtask
    task pw_case(input [7:0] wd, input [7:0] exp);
        begin
            pow_seq({8'h00, wd});
            check_read(`PCPC_ADDR_POW_CTRL, {8'h00, exp});
            repeat (2) @(posedge ref_clk);
            #1;
            check({12'h000, xtal_en, pll_en, peri_en, core_en}, {12'h000, exp[6:3]});
        end
    endtask
    // gap counts cycles since the previous tick; the first call may see a partial period
    task wait_tick(output [15:0] g);
        begin
            g = 16'h0001;
            @(posedge ref_clk);
            #1;
            while (core_tick !== 1'b1) begin
                if (g == 16'h03e8) begin
                    num_errors = num_errors + 1;
                    stop_test;
                end
                @(posedge ref_clk);
                #1;
                g = g + 16'h0001;
            end
        end
    endtask
    task pulse_wake;
        begin
            @(posedge ref_clk);
            wake <= 1'b1;
            @(posedge ref_clk);
            wake <= 1'b0;
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_read(`PCPC_ADDR_POW_CTRL, 16'h007b);
        check_read(`PCPC_ADDR_PLL_SRC, 16'h0000);
        check_read(`PCPC_ADDR_POW_KEY1, 16'h0000);
        check_read(32'hffff0500, 16'h0000);
        wait_tick(gap);
        wait_tick(gap);
        wait_tick(gap);
        check(gap, 16'h0010);
        check({13'h0000, core_div}, 16'h0003);
        bus_write(`PCPC_ADDR_POW_CTRL, 16'h0078);
        check_read(`PCPC_ADDR_POW_CTRL, 16'h007b);
        bad_pow(16'h0002, 16'h00f4);
        bad_pow(16'h0101, 16'h00f4);
        bad_pow(16'h0001, 16'h00f5);
        bus_write(`PCPC_ADDR_PLL_KEY1, `PCPC_PLL_KEY1_VAL);
        bus_write(`PCPC_ADDR_PLL_SRC, 16'h0004);
        check_read(`PCPC_ADDR_PLL_SRC, 16'h0000);
        // divider codes with their core clock periods
        for (i = 0; i < 8; i = i + 1) begin
            pow_seq({8'h00, 5'h0f, i[2:0]});
            wait_tick(gap);
            wait_tick(gap);
            wait_tick(gap);
            check(gap, 16'h0002 << i);
            check({13'h0000, core_div}, {13'h0000, i[2:0]});
        end
        pw_case(8'hff, 8'h7f);
        pw_case(8'h5b, 8'h7b);
        pw_case(8'h73, 8'h73);
        pw_case(8'h6b, 8'h7b);
        pw_case(8'h3b, 8'h3b);
        pw_case(8'h43, 8'h43);
        pulse_wake;
        check_read(`PCPC_ADDR_POW_CTRL, 16'h007b);
        // crystal request waits for nap, then holds after wake
        pll_seq(16'h0002, 16'h0000);
        pw_case(8'h63, 8'h63);
        check({14'h0000, src}, 16'h0001);
        pulse_wake;
        check_read(`PCPC_ADDR_PLL_SRC, 16'h0002);
        check({14'h0000, src}, 16'h0001);
        for (i = 0; i < 4; i = i + 1)
            if (i != 2) pll_seq(i[15:0], 16'h0000);
        pll_seq(16'h0004, 16'h0002);
        @(posedge ref_clk);
        ext_mode0 <= 1'b1;
        ext_base = ext_cnt;
        for (i = 0; i < 8; i = i + 1) begin
            repeat (3) @(posedge ref_clk);
            ext_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            ext_pin <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        #1;
        check(ext_cnt - ext_base, 16'h0004);
        // recovery reset in mid-run, as software sees after a watchdog reset
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_read(`PCPC_ADDR_POW_CTRL, 16'h007b);
        check_read(`PCPC_ADDR_PLL_SRC, 16'h0000);
        stop_test;
    end
endmodule
